/* logic/aat_defines.svh */
// aat_defines.svh: field positions, encodings, offsets and reset values
// for the add/and/direction-load execution slice.
// assumes: included by bare name from the package and the design files.
`ifndef AAT_DEFINES_SVH
`define AAT_DEFINES_SVH

// ----------------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------------
`define AAT_INSTR_W        12
`define AAT_DATA_W         8
`define AAT_FADDR_W        5
`define AAT_OPC6_HI        11
`define AAT_OPC6_LO        6
`define AAT_OPC4_HI        11
`define AAT_OPC4_LO        8
`define AAT_DEST_BIT       5
`define AAT_FADDR_HI       4
`define AAT_LIT_HI         7
`define AAT_LIT_LO         0
`define AAT_DIRPFX_HI      11
`define AAT_DIRPFX_LO      3
`define AAT_DIRSEL_HI      2

// ----------------------------------------------------------------------
// opcode encodings
// ----------------------------------------------------------------------
`define AAT_OPC6_ADD       6'h07
`define AAT_OPC6_ANDF      6'h05
`define AAT_OPC4_ANDL      4'hE
`define AAT_DIRPFX         9'h000

// ----------------------------------------------------------------------
// file addresses
// ----------------------------------------------------------------------
`define AAT_FA_TIMER       5'h01
`define AAT_FA_PORT0       5'h05
`define AAT_FA_PORT1       5'h06
`define AAT_FA_PORT2       5'h07
`define AAT_DIRSEL_PORT0   3'h5
`define AAT_DIRSEL_PORT1   3'h6
`define AAT_DIRSEL_PORT2   3'h7

// ----------------------------------------------------------------------
// alu bit positions
// ----------------------------------------------------------------------
`define AAT_NIB_W          4
`define AAT_NIB_HI         3

// ----------------------------------------------------------------------
// register port offsets and reset values
// ----------------------------------------------------------------------
`define AAT_RA_W           3
`define AAT_RA_ACC         3'h0
`define AAT_RA_FLAGS       3'h1
`define AAT_RA_DIR0        3'h2
`define AAT_RA_DIR1        3'h3
`define AAT_RA_DIR2        3'h4
`define AAT_RA_CTRL        3'h5
`define AAT_FLG_C          0
`define AAT_FLG_DC         1
`define AAT_FLG_Z          2
`define AAT_CTRL_PSA       0
`define AAT_ACC_RST        8'h00
`define AAT_DIR_RST        8'hFF
`define AAT_ZERO8          8'h00

`endif

/* logic/aat_pkg.sv */
// aat_pkg.sv: types shared by the execution slice and its alu.
// assumes: aat_defines.svh is on the include path.
`include "aat_defines.svh"

package aat_pkg;

    typedef logic [`AAT_DATA_W-1:0]  aat_byte_t;
    typedef logic [2:0][`AAT_DATA_W-1:0] aat_ports_t;

    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } aat_flags_t;

    typedef struct packed {
        logic                    we;
        logic [`AAT_FADDR_W-1:0] addr;
        aat_byte_t               data;
    } aat_fwr_t;

    typedef enum logic [2:0] {
        AAT_OP_NONE,
        AAT_OP_ADD,
        AAT_OP_ANDF,
        AAT_OP_ANDL,
        AAT_OP_DIR
    } aat_op_t;

endpackage : aat_pkg

/* logic/aat_alu.sv */
// aat_alu.sv: combinational result and flag logic for add and and.
// assumes: operands already selected by the caller; no clock here.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aat_alu (
    input  aat_pkg::aat_op_t    op,
    input  aat_pkg::aat_byte_t  acc,
    input  aat_pkg::aat_byte_t  opnd,
    input  aat_pkg::aat_flags_t flags_in,
    output aat_pkg::aat_byte_t  res,
    output aat_pkg::aat_flags_t flags_out
);
    import aat_pkg::*;

    function automatic logic is_zero(input aat_byte_t v);
        is_zero = (v == `AAT_ZERO8);
    endfunction : is_zero

    // ------------------------------------------------------------------
    // add with carry from bit 7 and bit 3
    // ------------------------------------------------------------------
    logic [`AAT_DATA_W:0]  sum9;
    logic [`AAT_NIB_W:0]   sum5;
    aat_byte_t             and8;

    assign sum9 = {1'b0, acc} + {1'b0, opnd};
    assign sum5 = {1'b0, acc[`AAT_NIB_HI:0]} + {1'b0, opnd[`AAT_NIB_HI:0]};
    assign and8 = acc & opnd;

    always_comb
    begin
        res       = acc;
        flags_out = flags_in;
        case (op)
            AAT_OP_ADD:
            begin
                res          = sum9[`AAT_DATA_W-1:0];
                flags_out.c  = sum9[`AAT_DATA_W];
                flags_out.dc = sum5[`AAT_NIB_W];
                flags_out.z  = is_zero(sum9[`AAT_DATA_W-1:0]);
            end
            AAT_OP_ANDF, AAT_OP_ANDL:
            begin
                res         = and8;
                flags_out.z = is_zero(and8);
            end
            default:
            begin
                res       = acc;
                flags_out = flags_in;
            end
        endcase
    end

endmodule : aat_alu

/* logic/aat_exec.sv */
// aat_exec.sv: execution slice for add-to-acc, and-with-acc, and-literal
// and port-direction load, with timer prescaler clear on timer writes.
// assumes: one instruction per mclk with instr_valid; file read data is
// combinational from file_raddr; pins are synchronous to mclk.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aat_exec (
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    input  wire logic [`AAT_INSTR_W-1:0] instr,
    input  wire logic                    instr_valid,
    output      logic [`AAT_FADDR_W-1:0] file_raddr,
    input  wire aat_pkg::aat_byte_t      file_rdata,
    output      aat_pkg::aat_fwr_t       file_wr,
    input  wire aat_pkg::aat_ports_t     pin_in,
    output      aat_pkg::aat_ports_t     pin_oe,
    output      logic                    presc_clr,
    output      aat_pkg::aat_byte_t      acc,
    output      aat_pkg::aat_flags_t     flags,
    input  wire logic [`AAT_RA_W-1:0]    reg_addr,
    input  wire aat_pkg::aat_byte_t      reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output      aat_pkg::aat_byte_t      reg_rdata
);
    import aat_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    aat_byte_t   acc_r,   acc_nxt;
    aat_flags_t  flags_r, flags_nxt;
    aat_ports_t  dir_r,   dir_nxt;
    logic        psa_r;
    aat_fwr_t    fwr_r,   fwr_nxt;
    logic        pclr_r,  pclr_nxt;
    aat_byte_t   rdata_r, rdata_nxt;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [5:0]              opc6;
    logic [3:0]              opc4;
    logic                    dest_file;
    logic [`AAT_FADDR_W-1:0] faddr;
    aat_byte_t               literal;
    logic [2:0]              dir_sel;
    logic                    is_dir_pfx;
    aat_op_t                 op;

    assign opc6       = instr[`AAT_OPC6_HI:`AAT_OPC6_LO];
    assign opc4       = instr[`AAT_OPC4_HI:`AAT_OPC4_LO];
    assign dest_file  = instr[`AAT_DEST_BIT];
    assign faddr      = instr[`AAT_FADDR_HI:0];
    assign literal    = instr[`AAT_LIT_HI:`AAT_LIT_LO];
    assign dir_sel    = instr[`AAT_DIRSEL_HI:0];
    assign is_dir_pfx = (instr[`AAT_DIRPFX_HI:`AAT_DIRPFX_LO] == `AAT_DIRPFX);

    assign op = !instr_valid                   ? AAT_OP_NONE :
                (opc6 == `AAT_OPC6_ADD)        ? AAT_OP_ADD  :
                (opc6 == `AAT_OPC6_ANDF)       ? AAT_OP_ANDF :
                (opc4 == `AAT_OPC4_ANDL)       ? AAT_OP_ANDL :
                is_dir_pfx                     ? AAT_OP_DIR  :
                                                 AAT_OP_NONE;

    // ------------------------------------------------------------------
    // operand select: io ports read from the pins
    // ------------------------------------------------------------------
    logic      addr_is_port;
    aat_byte_t pin_val;
    aat_byte_t file_src;
    aat_byte_t opnd;

    assign file_raddr   = faddr;
    assign addr_is_port = (faddr == `AAT_FA_PORT0) ||
                          (faddr == `AAT_FA_PORT1) ||
                          (faddr == `AAT_FA_PORT2);
    assign pin_val  = (faddr == `AAT_FA_PORT0) ? pin_in[0] :
                      (faddr == `AAT_FA_PORT1) ? pin_in[1] : pin_in[2];
    assign file_src = addr_is_port ? pin_val : file_rdata;
    assign opnd     = (op == AAT_OP_ANDL) ? literal : file_src;

    // ------------------------------------------------------------------
    // alu
    // ------------------------------------------------------------------
    aat_byte_t  alu_res;
    aat_flags_t alu_flags;

    aat_alu u_alu (
        .op        (op),
        .acc       (acc_r),
        .opnd      (opnd),
        .flags_in  (flags_r),
        .res       (alu_res),
        .flags_out (alu_flags)
    );

    // ------------------------------------------------------------------
    // destination and side effects
    // ------------------------------------------------------------------
    logic is_file_op;
    logic wr_file;
    logic wr_acc;
    logic dir_hit;

    assign is_file_op = (op == AAT_OP_ADD) || (op == AAT_OP_ANDF);
    assign wr_file    = is_file_op && dest_file;
    assign wr_acc     = (is_file_op && !dest_file) ||
                        (op == AAT_OP_ANDL);
    assign dir_hit    = (op == AAT_OP_DIR) &&
                        ((dir_sel == `AAT_DIRSEL_PORT0) ||
                         (dir_sel == `AAT_DIRSEL_PORT1) ||
                         (dir_sel == `AAT_DIRSEL_PORT2));

    assign fwr_nxt.we   = wr_file;
    assign fwr_nxt.addr = faddr;
    assign fwr_nxt.data = wr_file ? alu_res : fwr_r.data;
    assign pclr_nxt     = wr_file && (faddr == `AAT_FA_TIMER) &&
                          psa_r;

    // ------------------------------------------------------------------
    // register port: instruction writes win over software writes
    // ------------------------------------------------------------------
    logic sw_acc, sw_flags, sw_dir0, sw_dir1, sw_dir2, sw_ctrl;

    assign sw_acc   = reg_wr && (reg_addr == `AAT_RA_ACC);
    assign sw_flags = reg_wr && (reg_addr == `AAT_RA_FLAGS);
    assign sw_dir0  = reg_wr && (reg_addr == `AAT_RA_DIR0);
    assign sw_dir1  = reg_wr && (reg_addr == `AAT_RA_DIR1);
    assign sw_dir2  = reg_wr && (reg_addr == `AAT_RA_DIR2);
    assign sw_ctrl  = reg_wr && (reg_addr == `AAT_RA_CTRL);

    assign acc_nxt = wr_acc ? alu_res :
                     sw_acc ? reg_wdata : acc_r;

    assign flags_nxt = (op != AAT_OP_NONE) ? alu_flags :
                       sw_flags ? aat_flags_t'({reg_wdata[`AAT_FLG_Z],
                                                reg_wdata[`AAT_FLG_DC],
                                                reg_wdata[`AAT_FLG_C]})
                                : flags_r;

    assign dir_nxt[0] = (dir_hit && dir_sel == `AAT_DIRSEL_PORT0) ? acc_r :
                        sw_dir0 ? reg_wdata : dir_r[0];
    assign dir_nxt[1] = (dir_hit && dir_sel == `AAT_DIRSEL_PORT1) ? acc_r :
                        sw_dir1 ? reg_wdata : dir_r[1];
    assign dir_nxt[2] = (dir_hit && dir_sel == `AAT_DIRSEL_PORT2) ? acc_r :
                        sw_dir2 ? reg_wdata : dir_r[2];

    assign rdata_nxt =
        !reg_rd                      ? rdata_r :
        (reg_addr == `AAT_RA_ACC)    ? acc_r :
        (reg_addr == `AAT_RA_FLAGS)  ? {5'h00, flags_r.z, flags_r.dc,
                                        flags_r.c} :
        (reg_addr == `AAT_RA_DIR0)   ? dir_r[0] :
        (reg_addr == `AAT_RA_DIR1)   ? dir_r[1] :
        (reg_addr == `AAT_RA_DIR2)   ? dir_r[2] :
        (reg_addr == `AAT_RA_CTRL)   ? {7'h00, psa_r} : `AAT_ZERO8;

    // ------------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_r   <= `AAT_ACC_RST;
            flags_r <= '0;
            dir_r   <= {3{`AAT_DIR_RST}};
            fwr_r   <= '0;
            pclr_r  <= 1'b0;
            rdata_r <= `AAT_ZERO8;
        end
        else
        begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
            dir_r   <= dir_nxt;
            fwr_r   <= fwr_nxt;
            pclr_r  <= pclr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            psa_r <= 1'b0;
        else if (sw_ctrl)
            psa_r <= reg_wdata[`AAT_CTRL_PSA];
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign file_wr   = fwr_r;
    assign presc_clr = pclr_r;
    assign acc       = acc_r;
    assign flags     = flags_r;
    assign pin_oe    = ~dir_r;
    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_RMW_PINS: assert property (
        (op == AAT_OP_ADD && dest_file && faddr == `AAT_FA_PORT1)
        |=> file_wr.data ==
            8'($past(acc_r) + $past(pin_in[1])))
        else $error("port add did not use pin levels");

    AST_DIR_LOAD: assert property (
        (dir_hit && dir_sel == `AAT_DIRSEL_PORT2)
        |=> dir_r[2] == $past(acc_r) && dir_r[0] == $past(dir_r[0]))
        else $error("direction load wrong latch or value");

    AST_OE_POLARITY: assert property (
        (op == AAT_OP_DIR && dir_sel == `AAT_DIRSEL_PORT0)
        |=> pin_oe[0] == ~$past(acc_r))
        else $error("driver enable not inverse of direction bit");

    AST_PRESC_CLR: assert property (
        presc_clr |-> $past(wr_file) && $past(psa_r) &&
                      file_wr.addr == `AAT_FA_TIMER)
        else $error("prescaler clear without timer write");

    AST_ADD_ACC: assert property (
        (op == AAT_OP_ADD && !dest_file)
        |=> acc_r == 8'($past(acc_r) + $past(file_src)) && !file_wr.we)
        else $error("add to acc result wrong");

    AST_DEST_FILE: assert property (
        (is_file_op && dest_file)
        |=> file_wr.we && acc_r == $past(acc_r) &&
            file_wr.addr == $past(faddr))
        else $error("file destination not honoured");

    AST_ANDF_FLAGS: assert property (
        (op == AAT_OP_ANDF)
        |=> flags_r.c == $past(flags_r.c) && flags_r.dc == $past(flags_r.dc))
        else $error("and changed carry flags");

    AST_ANDL: assert property (
        (op == AAT_OP_ANDL)
        |=> acc_r == ($past(acc_r) &
                      $past(instr[`AAT_LIT_HI:`AAT_LIT_LO])) && !file_wr.we)
        else $error("and literal result wrong");

    AST_FLAGS_ADD: assert property (
        (op == AAT_OP_ADD)
        ##1 (1'b1) |-> flags_r.z == (file_wr.we ? file_wr.data == `AAT_ZERO8
                                                 : acc_r == `AAT_ZERO8))
        else $error("zero flag disagrees with result");

endmodule : aat_exec

/* dv/aat_exec_tb.sv */
// aat_exec_tb.sv: self-checking bench for the add/and/direction slice.
// assumes: aat_pkg and aat_exec compiled first, header on include path.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aat_exec_tb;
    import aat_pkg::*;

    logic                    mclk        = 1'b0;
    logic                    reset_n     = 1'b0;
    logic [`AAT_INSTR_W-1:0] instr       = 12'h000;
    logic                    instr_valid = 1'b0;
    logic [`AAT_FADDR_W-1:0] file_raddr;
    aat_byte_t               file_rdata;
    aat_fwr_t                file_wr;
    aat_ports_t              pin_in      = 24'h000000;
    aat_ports_t              pin_oe;
    logic                    presc_clr;
    aat_byte_t               acc;
    aat_flags_t              flags;
    logic [`AAT_RA_W-1:0]    reg_addr    = 3'h0;
    aat_byte_t               reg_wdata   = 8'h00;
    logic                    reg_wr      = 1'b0;
    logic                    reg_rd      = 1'b0;
    aat_byte_t               reg_rdata;
    aat_byte_t               fmem [32]   = '{default: 8'h00};
    int                      errors;
    int                      checked;
    int                      m_acc, m_psa;
    bit                      m_z, m_dc, m_c;
    int                      m_dir [3]   = '{255, 255, 255};

    // ------------------------------------------------------------------
    // clock, file register array, design
    // ------------------------------------------------------------------
    always #25 mclk = ~mclk;
    assign file_rdata = fmem[file_raddr];

    aat_exec uut (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .instr       (instr),
        .instr_valid (instr_valid),
        .file_raddr  (file_raddr),
        .file_rdata  (file_rdata),
        .file_wr     (file_wr),
        .pin_in      (pin_in),
        .pin_oe      (pin_oe),
        .presc_clr   (presc_clr),
        .acc         (acc),
        .flags       (flags),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata)
    );

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        checked++;
        if (e !== g)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask : chk
    task automatic close_out;
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    function automatic logic [23:0] oe_exp();
        return 24'(~((m_dir[2] << 16) | (m_dir[1] << 8) | m_dir[0]));
    endfunction : oe_exp

    // ------------------------------------------------------------------
    // register port master
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [2:0] a, input int e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("reg_rdata", 24'(e), {16'h0000, reg_rdata});
    endtask : reg_read

    // ------------------------------------------------------------------
    // one instruction against the model
    // ------------------------------------------------------------------
    task automatic step(input logic [11:0] i);
        aat_ports_t pv;
        int         f, fv, opnd, r = 0, wr_f = 0, clr = 0;
        @(posedge mclk);
        pv = 24'($urandom);
        f = i[4:0];
        fv = $urandom_range(255);
        fmem[f]     <= 8'(fv);
        instr       <= i;
        instr_valid <= 1'b1;
        pin_in      <= pv;
        opnd = (f >= 5 && f <= 7) ? pv[f-5] : fv;
        if (i[11:6] == 6'h07 || i[11:6] == 6'h05)
        begin
            if (i[11:6] == 6'h07)
            begin
                r = m_acc + opnd;
                m_c = (r > 255);
                m_dc = ((m_acc & 15) + (opnd & 15)) > 15;
                r = r & 255;
            end
            else
                r = m_acc & opnd;
            m_z = (r == 0);
            wr_f = i[5];
            clr = i[5] && f == 1 && m_psa;
            if (!i[5])
                m_acc = r;
        end
        else if (i[11:8] == 4'hE)
        begin
            m_acc = m_acc & i[7:0];
            m_z = (m_acc == 0);
        end
        else if (i[11:3] == 9'h000 && i[2:0] >= 5)
            m_dir[i[2:0]-5] = m_acc;
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
        chk("acc", 24'(m_acc), {16'h0000, acc});
        chk("flags", 24'({m_z, m_dc, m_c}), {21'h0, flags});
        chk("file_we", 24'(wr_f), {23'h0, file_wr.we});
        if (wr_f)
            chk("file_wr", 24'((f << 8) | r), 24'(file_wr[12:0]));
        chk("presc_clr", 24'(clr), {23'h0, presc_clr});
        chk("pin_oe", oe_exp(), pin_oe);
    endtask : step
    task automatic run_random(input int n);
        logic [7:0]  b;
        logic [11:0] ins;
        repeat (n)
        begin
            b = 8'($urandom);
            case ($urandom_range(5))
                0: ins = {6'h07, b[5:0]};
                1: ins = {6'h05, b[5:0]};
                2: ins = {4'hE, b};
                3: ins = {9'h000, b[2:0]};
                4: ins = {6'h07, 1'b1, 5'h01};
                default: ins = {4'hC, b};
            endcase
            step(ins);
        end
    endtask : run_random

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        #(50 * 3000);
        errors++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'h45EF));
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk("pin_oe", 24'h000000, pin_oe);
        chk("presc_clr", 24'h0, {23'h0, presc_clr});
        for (int a = 0; a < 8; a++)
            reg_read(3'(a), (a >= 2 && a <= 4) ? 255 : 0);
        m_acc = $urandom_range(255);
        reg_write(3'h0, 8'(m_acc));
        run_random(150);
        reg_write(3'h5, 8'h01);
        m_psa = 1;
        reg_write(3'h1, 8'h07);
        {m_z, m_dc, m_c} = 3'b111;
        reg_write(3'h3, 8'h0F);
        m_dir[1] = 15;
        run_random(150);
        reg_write(3'h7, 8'hA5);
        reg_read(3'h7, 0);
        reg_read(3'h1, {m_z, m_dc, m_c});
        for (int a = 0; a < 3; a++)
            reg_read(3'(a + 2), m_dir[a]);
        close_out();
    end

endmodule : aat_exec_tb
